// ==== design/lcr_pkg.sv ====
`default_nettype none
package lcr_pkg;
  // register byte offsets on the bus
  localparam logic [3:0] LCR_CAP_OFS    = 4'h0;  // capability word (word 78 image)
  localparam logic [3:0] LCR_SPEED_OFS  = 4'h4;  // speed and sleep word (word 77 image)
  localparam logic [3:0] LCR_ENABLE_OFS = 4'h8;  // enable word (word 79 image), writable
  localparam logic [3:0] LCR_RAW_OFS    = 4'hC;  // requested straps before checks
  // capability word field positions
  localparam int LCR_CAP_NZ_OFS_BIT   = 1;
  localparam int LCR_CAP_AUTOACT_BIT  = 2;
  localparam int LCR_CAP_DEVPM_BIT    = 3;
  localparam int LCR_CAP_INORDER_BIT  = 4;
  localparam int LCR_CAP_NONDATA_BIT  = 5;
  localparam int LCR_CAP_HWFC_BIT     = 5;
  localparam int LCR_CAP_SNDRCV_BIT   = 6;
  localparam int LCR_CAP_KEEP_BIT     = 6;
  localparam int LCR_CAP_AUTOSNS_BIT  = 7;
  localparam int LCR_CAP_SLEEP_BIT    = 8;
  localparam int LCR_CAP_HYBRID_BIT   = 9;
  localparam int LCR_CAP_PMKEEP_BIT   = 10;
  localparam int LCR_CAP_REBUILD_BIT  = 11;
  // speed word field positions
  localparam int LCR_SPD_LSB          = 1;
  localparam int LCR_SPD_MSB          = 3;
  localparam int LCR_SPD_REDPWR_BIT   = 7;
  localparam int LCR_SPD_QUEUED_BIT   = 8;
  localparam int LCR_SPD_HOSTPM_BIT   = 9;
  localparam int LCR_SPD_TIMVAR_BIT   = 10;
  // enable word field positions
  localparam int LCR_EN_NZ_OFS_BIT    = 1;
  localparam int LCR_EN_INORDER_BIT   = 4;
  localparam int LCR_EN_HWFC_BIT      = 5;
  localparam int LCR_EN_DEVPM_BIT     = 3;
  localparam int LCR_EN_REBUILD_BIT   = 11;
  localparam logic [15:0] LCR_ENABLE_RST = 16'h0000;
  // link speed codes
  typedef enum logic [2:0] {
    LCR_SPD_NONE = 3'h0,
    LCR_SPD_GEN1 = 3'h1,
    LCR_SPD_GEN2 = 3'h2,
    LCR_SPD_GEN3 = 3'h3
  } lcr_speed_t;
  localparam int LCR_GEN1_MBPS = 1500;
  localparam int LCR_GEN2_MBPS = 3000;
  localparam int LCR_GEN3_MBPS = 6000;
endpackage
`default_nettype wire

// ==== design/lcr_link_capability_report.sv ====
// Function
// - non-data queued bit needs queued support; bit 5 is shared and hardware control sets it without queued
// - send/receive queued bit needs queued support; bit 6 is shared and settings-kept sets it without queued
// - zero offset only unless offsets supported
// - auto-activate bit only when supported
// - no host power requests forces device bit
// - in-order bit defaults zero, guarantees ordering
// - without in-order, interleaving allowed with offsets
// - no hardware control forces its enable zero
// - settings-kept bit equals feature support; bit 6 is shared and also set by send/receive queued
// - autosense bit needs queued support
// - sleep support forces timing variables bit
// - reduced-power sleep bit forces sleep bit
// - hybrid bit only when feature supported
// - power enable kept across link reset
// - rebuild needs queued; enabled state reported
// - three-bit speed code, others reserved
// - speed code mirrored at bits 3:1
// - speed reflects only the attached link
// - gen1/2/3 mean 1.5/3.0/6.0 Gbps
// - host request bit means partial/slumber support
//
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/100ps
`default_nettype none
module lcr_link_capability_report (
  // clock, reset, enable
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   wb_err_o,
  // requested device configuration straps
  input  wire logic              cfg_queued,
  input  wire logic              cfg_nondata,
  input  wire logic              cfg_sndrcv,
  input  wire logic              cfg_nz_ofs,
  input  wire logic              cfg_autoact,
  input  wire logic              cfg_host_pm,
  input  wire logic              cfg_device_started_link_power_request,
  input  wire logic              cfg_inorder,
  input  wire logic              cfg_hwfc,
  input  wire logic              cfg_settings_kept_over_link_reset,
  input  wire logic              cfg_autosense,
  input  wire logic              cfg_sleep,
  input  wire logic              cfg_redpwr,
  input  wire logic              cfg_hybrid,
  input  wire logic              cfg_pm_keep,
  input  wire logic              cfg_rebuild,
  // link status from the attached phy
  input  wire logic [2:0]        phy_speed,
  input  wire logic              link_reset,
  // checked capabilities and enables for the rest of the device
  output logic                   nz_offset_allowed,
  output logic                   interleave_allowed,
  output logic                   inorder_required,
  output logic                   hwfc_enabled,
  output logic                   device_pm_enabled,
  output logic                   rebuild_enabled,
  output logic      [15:0]       cap_word,
  output logic      [15:0]       speed_word
);
  import lcr_pkg::*;

  // consistency checks applied to the requested straps
  wire logic q_ok       = cfg_queued;
  wire logic c_nondata  = cfg_nondata & q_ok;
  wire logic c_sndrcv   = cfg_sndrcv & q_ok;
  wire logic c_nz_ofs   = cfg_nz_ofs;
  wire logic c_autoact  = cfg_autoact;
  wire logic c_hostpm   = cfg_host_pm;
  wire logic c_devpm    = cfg_device_started_link_power_request | ~cfg_host_pm;
  wire logic c_inorder  = cfg_inorder;
  wire logic c_hwfc     = cfg_hwfc;
  wire logic c_keep     = cfg_settings_kept_over_link_reset;
  wire logic c_autosns  = cfg_autosense & q_ok;
  wire logic c_redpwr   = cfg_redpwr;
  wire logic c_sleep    = cfg_sleep | cfg_redpwr;
  wire logic c_timvar   = c_sleep;
  wire logic c_hybrid   = cfg_hybrid;
  wire logic c_pmkeep   = cfg_pm_keep & c_keep;
  wire logic c_rebuild  = cfg_rebuild & q_ok;

  // speed code filter: reserved codes report as not supported
  function automatic logic [2:0] lcr_speed_check(input logic [2:0] c);
    lcr_speed_check = (c > 3'(LCR_SPD_GEN3)) ? 3'(LCR_SPD_NONE) : c;
  endfunction

  // capability word image; straps pass through a register only, no bus writes
  logic [15:0] cap_nxt;
  logic [15:0] cap_r;
  always_comb begin
    cap_nxt = 16'h0000;
    cap_nxt[LCR_CAP_NZ_OFS_BIT]  = c_nz_ofs;
    cap_nxt[LCR_CAP_AUTOACT_BIT] = c_autoact;
    cap_nxt[LCR_CAP_DEVPM_BIT]   = c_devpm;
    cap_nxt[LCR_CAP_INORDER_BIT] = c_inorder;
    cap_nxt[LCR_CAP_NONDATA_BIT] = c_nondata | c_hwfc;
    cap_nxt[LCR_CAP_SNDRCV_BIT]  = c_sndrcv | c_keep;
    cap_nxt[LCR_CAP_AUTOSNS_BIT] = c_autosns;
    cap_nxt[LCR_CAP_SLEEP_BIT]   = c_sleep;
    cap_nxt[LCR_CAP_HYBRID_BIT]  = c_hybrid;
    cap_nxt[LCR_CAP_PMKEEP_BIT]  = c_pmkeep;
    cap_nxt[LCR_CAP_REBUILD_BIT] = c_rebuild;
  end

  // speed word image, speed from the directly attached link only
  logic [15:0] spd_nxt;
  logic [15:0] spd_r;
  always_comb begin
    spd_nxt = 16'h0000;
    spd_nxt[LCR_SPD_MSB:LCR_SPD_LSB] = lcr_speed_check(phy_speed);
    spd_nxt[LCR_SPD_REDPWR_BIT] = c_redpwr & c_sleep;
    spd_nxt[LCR_SPD_QUEUED_BIT] = q_ok;
    spd_nxt[LCR_SPD_HOSTPM_BIT] = c_hostpm;
    spd_nxt[LCR_SPD_TIMVAR_BIT] = c_timvar;
  end

  // bus decode
  wire logic       bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire logic       hit_cap  = (wb_adr_i == LCR_CAP_OFS);
  wire logic       hit_spd  = (wb_adr_i == LCR_SPEED_OFS);
  wire logic       hit_en   = (wb_adr_i == LCR_ENABLE_OFS);
  wire logic       hit_raw  = (wb_adr_i == LCR_RAW_OFS);
  wire logic       hit_any  = hit_cap | hit_spd | hit_en | hit_raw;
  wire logic       en_wr    = bus_req & wb_we_i & hit_en;
  wire logic [15:0] raw_word = {cfg_rebuild, cfg_pm_keep, cfg_hybrid, cfg_redpwr, cfg_sleep,
                                cfg_autosense, cfg_settings_kept_over_link_reset, cfg_hwfc,
                                cfg_inorder, cfg_device_started_link_power_request, cfg_host_pm,
                                cfg_autoact, cfg_nz_ofs, cfg_sndrcv, cfg_nondata, cfg_queued};

  // enable word: write data masked by what is supported
  logic [15:0] en_r;
  logic [15:0] en_wdata;
  logic [15:0] en_nxt;
  always_comb begin
    en_wdata = en_r;
    if (wb_sel_i[0]) begin
      en_wdata[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      en_wdata[15:8] = wb_dat_i[15:8];
    end
    en_nxt = 16'h0000;
    en_nxt[LCR_EN_NZ_OFS_BIT]  = en_wdata[LCR_EN_NZ_OFS_BIT] & c_nz_ofs;
    en_nxt[LCR_EN_INORDER_BIT] = en_wdata[LCR_EN_INORDER_BIT] & c_inorder;
    en_nxt[LCR_EN_HWFC_BIT]    = en_wdata[LCR_EN_HWFC_BIT] & c_hwfc;
    en_nxt[LCR_EN_DEVPM_BIT]   = en_wdata[LCR_EN_DEVPM_BIT] & c_devpm;
    en_nxt[LCR_EN_REBUILD_BIT] = en_wdata[LCR_EN_REBUILD_BIT] & c_rebuild;
  end

  // link reset clears all enables; only the device power enable survives, and only when power setting is preserved
  logic [15:0] en_keep;
  always_comb begin
    en_keep = LCR_ENABLE_RST;
    en_keep[LCR_EN_DEVPM_BIT] = en_r[LCR_EN_DEVPM_BIT] & c_pmkeep;
  end

  // read mux
  wire logic [15:0] rd_word = hit_cap ? cap_r :
                              hit_spd ? spd_r :
                              hit_en  ? en_r  :
                              hit_raw ? raw_word : 16'h0000;

  // image and enable registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_r <= 16'h0000;
      spd_r <= 16'h0000;
      en_r  <= LCR_ENABLE_RST;
    end else if (clk_en) begin
      cap_r <= cap_nxt;
      spd_r <= spd_nxt;
      if (link_reset) begin
        en_r <= en_keep;
      end else if (en_wr) begin
        en_r <= en_nxt;
      end else begin
        en_r <= en_r & cap_filter(en_r);
      end
    end
  end

  // drops enables whose capability has gone away
  function automatic logic [15:0] cap_filter(input logic [15:0] e);
    cap_filter = 16'hFFFF;
    cap_filter[LCR_EN_NZ_OFS_BIT]  = c_nz_ofs;
    cap_filter[LCR_EN_INORDER_BIT] = c_inorder;
    cap_filter[LCR_EN_HWFC_BIT]    = c_hwfc;
    cap_filter[LCR_EN_DEVPM_BIT]   = c_devpm;
    cap_filter[LCR_EN_REBUILD_BIT] = c_rebuild;
    cap_filter = cap_filter & e;
  endfunction

  // bus answer, one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (clk_en) begin
      wb_ack_o <= bus_req & hit_any;
      wb_err_o <= bus_req & ~hit_any;
      if (bus_req) begin
        wb_dat_o <= {16'h0000, rd_word};
      end
    end
  end

  // outputs to the data path
  assign cap_word           = cap_r;
  assign speed_word         = spd_r;
  assign nz_offset_allowed  = en_r[LCR_EN_NZ_OFS_BIT];
  assign inorder_required   = en_r[LCR_EN_INORDER_BIT] & nz_offset_allowed;
  assign interleave_allowed = ~en_r[LCR_EN_INORDER_BIT] & nz_offset_allowed;
  assign hwfc_enabled       = en_r[LCR_EN_HWFC_BIT];
  assign device_pm_enabled  = en_r[LCR_EN_DEVPM_BIT];
  assign rebuild_enabled    = en_r[LCR_EN_REBUILD_BIT];
endmodule // lcr_link_capability_report
`default_nettype wire

// ==== testbench/lcr_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcr_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  // bus handshake
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  // link and reports
  input wire logic [2:0]  phy_speed,
  input wire logic        nz_offset_allowed,
  input wire logic        interleave_allowed,
  input wire logic        inorder_required,
  input wire logic        rebuild_enabled,
  input wire logic [15:0] cap_word,
  input wire logic [15:0] speed_word
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // images hold real values once loaded after reset
  logic up_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) up_r <= 1'b0;
    else if (clk_en) up_r <= 1'b1;
  end
  // a taken request and its one-cycle answer
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && clk_en;
  endsequence
  sequence ans_s;
    (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
  endsequence
  a_bus_answer: assert property (req_s |=> ans_s)
    else $error("bus answer missing or too long");
  a_speed_mirror: assert property (rst_n && clk_en |=>
    speed_word[3:1] == (($past(phy_speed) > 3'h3) ? 3'h0 : $past(phy_speed)))
    else $error("speed code not mirrored");
  a_pm_either: assert property (up_r && !speed_word[9] |-> cap_word[3])
    else $error("no power request path reported");
  a_queued_gate: assert property (cap_word[7] || cap_word[11] |-> speed_word[8])
    else $error("queued bit set without queued support");
  a_sleep_timing: assert property (cap_word[8] |-> speed_word[10])
    else $error("sleep without timing bit");
  a_redpwr_sleep: assert property (speed_word[7] |-> cap_word[8])
    else $error("reduced power sleep without sleep bit");
  a_nz_gate: assert property ($rose(nz_offset_allowed) |-> cap_word[1])
    else $error("offset enable without capability");
  a_interleave_rule: assert property (interleave_allowed |-> nz_offset_allowed && !inorder_required)
    else $error("interleave allowed wrongly");
  a_rebuild_gate: assert property ($rose(rebuild_enabled) |-> cap_word[11] && speed_word[8])
    else $error("rebuild enabled without support");
endmodule // lcr_asserts
`default_nettype wire

// ==== testbench/lcr_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcr_host_model (
  // clock
  input  wire logic        ref_clk,
  // bus master side
  output var logic         cyc,
  output var logic         stb,
  output var logic         we,
  output var logic [3:0]   adr,
  output var logic [3:0]   sel,
  output var logic [31:0]  dat_w,
  input  wire logic [31:0] dat_r,
  input  wire logic        ack,
  input  wire logic        err
);
  // bus idle at time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    sel = 4'h0;
    dat_w = 32'h0;
  end
  // one classic cycle; rsp 0 ack, 1 err, 2 no answer
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] rsp);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    dat_w <= d;
    rsp = 2'h2;
    for (int n = 0; n < 20 && rsp == 2'h2; n++) begin
      @(posedge ref_clk);
      if (ack || err) rsp = {1'b0, err};
    end
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    dat_w <= ~d;
  endtask
endmodule // lcr_host_model
`default_nettype wire

// ==== testbench/lcr_link_capability_report_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcr_link_capability_report_bench;
  import lcr_pkg::*;
  // clock, reset, straps, link
  logic        ref_clk, rst_n, clk_en, link_reset;
  logic [15:0] st, cap, spd;
  logic [2:0]  phy;
  // bus and enable outputs
  logic        cyc, stb, we, ack, err, nz, il, io, hw, dp, rb;
  logic [3:0]  adr, sel;
  logic [31:0] dw, dr, q;
  logic [1:0]  r;
  int          failures, total_checks;
  lcr_link_capability_report lcr_link_capability_report_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .wb_err_o(err), .cfg_queued(st[0]), .cfg_nondata(st[1]), .cfg_sndrcv(st[2]),
    .cfg_nz_ofs(st[3]), .cfg_autoact(st[4]), .cfg_host_pm(st[5]), .cfg_device_started_link_power_request(st[6]),
    .cfg_inorder(st[7]), .cfg_hwfc(st[8]), .cfg_settings_kept_over_link_reset(st[9]), .cfg_autosense(st[10]),
    .cfg_sleep(st[11]), .cfg_redpwr(st[12]), .cfg_hybrid(st[13]), .cfg_pm_keep(st[14]), .cfg_rebuild(st[15]),
    .phy_speed(phy), .link_reset(link_reset), .nz_offset_allowed(nz), .interleave_allowed(il),
    .inorder_required(io), .hwfc_enabled(hw), .device_pm_enabled(dp), .rebuild_enabled(rb),
    .cap_word(cap), .speed_word(spd));
  lcr_host_model lcr_host_model_inst (.ref_clk(ref_clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
    .sel(sel), .dat_w(dw), .dat_r(dr), .ack(ack), .err(err));
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one bus cycle, a missing answer ends the run
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    lcr_host_model_inst.xfer(w, a, d, q, r);
    if (r == 2'h2) begin
      failures++;
      test_done();
    end
  endtask
  // expected images from the straps
  function automatic logic [15:0] exp_cap(input logic [15:0] s);
    exp_cap = {4'h0, s[15] & s[0], s[14] & s[9], s[13], s[11] | s[12], s[10] & s[0], (s[2] & s[0]) | s[9],
               (s[1] & s[0]) | s[8], s[7], s[6] | ~s[5], s[4], s[3], 1'b0};
  endfunction
  function automatic logic [15:0] exp_spd(input logic [15:0] s, input logic [2:0] c);
    exp_spd = {5'h0, s[11] | s[12], s[5], s[0], s[12], 3'h0, (c > 3'h3) ? 3'h0 : c, 1'b0};
  endfunction
  task automatic set_straps(input logic [15:0] v);
    st <= v;
    repeat (2) @(posedge ref_clk);
  endtask
  // strap combinations against both images
  task automatic test_straps();
    logic [15:0] v [5] = '{16'hFFFF, 16'hBCFE, 16'h0000, 16'h1020, 16'h0A21};
    foreach (v[i]) begin
      set_straps(v[i]);
      check("cap word", {16'h0, cap}, {16'h0, exp_cap(v[i])});
      check("speed word", {16'h0, spd}, {16'h0, exp_spd(v[i], phy)});
      bus(1'b0, LCR_CAP_OFS, 32'h0);
      check("cap read", q, {16'h0, exp_cap(v[i])});
      bus(1'b0, LCR_RAW_OFS, 32'h0);
      check("raw straps", q, {16'h0, v[i]});
    end
    $display("straps test done");
  endtask
  // every speed code, reserved ones included
  task automatic test_speed();
    for (int c = 0; c < 8; c++) begin
      phy <= 3'(c);
      bus(1'b0, LCR_SPEED_OFS, 32'h0);
      check("speed code", {29'h0, q[3:1]}, (c > 3) ? 32'h0 : 32'(c));
    end
    $display("speed test done");
  endtask
  // enable register, read-only places and an unmapped address
  task automatic test_enable();
    bus(1'b0, LCR_ENABLE_OFS, 32'h0);
    check("enable reset", q, {16'h0, LCR_ENABLE_RST});
    set_straps(16'hFFFF);
    bus(1'b1, LCR_ENABLE_OFS, 32'hFFFF);
    bus(1'b0, LCR_ENABLE_OFS, 32'h0);
    check("enable all", q, 32'h083A);
    check("enable outputs", {26'h0, nz, il, io, hw, dp, rb}, 32'h2F);
    bus(1'b1, LCR_ENABLE_OFS, 32'h2);
    check("interleave", {30'h0, il, io}, 32'h2);
    bus(1'b1, LCR_CAP_OFS, 32'h0);
    bus(1'b0, LCR_CAP_OFS, 32'h0);
    check("cap after write", q, {16'h0, exp_cap(16'hFFFF)});
    bus(1'b1, 4'h2, 32'h0);
    check("unmapped", {30'h0, r}, 32'h1);
    set_straps(16'h0020);
    bus(1'b1, LCR_ENABLE_OFS, 32'hFFFF);
    bus(1'b0, LCR_ENABLE_OFS, 32'h0);
    check("enable masked", q, 32'h0);
    $display("enable test done");
  endtask
  // link reset keeps only the device power enable, and only when kept
  task automatic test_link_reset();
    logic [15:0] v [2] = '{16'hFFFF, 16'hBFFF};
    foreach (v[i]) begin
      set_straps(v[i]);
      bus(1'b1, LCR_ENABLE_OFS, 32'hFFFF);
      link_reset <= 1'b1;
      @(posedge ref_clk);
      link_reset <= 1'b0;
      bus(1'b0, LCR_ENABLE_OFS, 32'h0);
      check("after link reset", q, (i == 0) ? 32'h8 : 32'h0);
    end
    $display("link reset test done");
  endtask
  // low clock enable freezes the images until it returns
  task automatic test_clk_en();
    set_straps(16'h0000);
    clk_en <= 1'b0;
    set_straps(16'hFFFF);
    check("frozen cap", {16'h0, cap}, {16'h0, exp_cap(16'h0000)});
    clk_en <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check("thawed cap", {16'h0, cap}, {16'h0, exp_cap(16'hFFFF)});
    $display("clock enable test done");
  endtask
  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // reset, then the scenarios
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    link_reset = 1'b0;
    st = 16'h0020;
    phy = 3'h2;
    failures = 0;
    total_checks = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_enable();
    test_straps();
    test_speed();
    test_link_reset();
    test_clk_en();
    test_done();
  end
endmodule // lcr_link_capability_report_bench
bind lcr_link_capability_report lcr_asserts lcr_asserts_inst (.ref_clk(ref_clk), .rst_n(rst_n),
  .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
  .phy_speed(phy_speed), .nz_offset_allowed(nz_offset_allowed), .interleave_allowed(interleave_allowed),
  .inorder_required(inorder_required), .rebuild_enabled(rebuild_enabled), .cap_word(cap_word),
  .speed_word(speed_word));
`default_nettype wire
